// [radio_ctrl_cal_sequencer.sv]
`timescale 1ns/10ps
module radio_ctrl_cal_sequencer
  import radio_ctrl_pkg::*;
#(
  parameter int FCAL_CYCLES = radio_ctrl_pkg::FCAL_CYC,
  parameter int OCAL_CYCLES = radio_ctrl_pkg::OCAL_CYC
) (
  input wire logic clock_in, // 40 MHz system clock
  input wire logic rst_in, // Power-on reset, async, active high
  input wire logic serial_clock_in, // Serial bus clock pin
  input wire logic serial_data_in, // Serial bus data pin
  input wire logic serial_latch_enable_in, // Serial latch enable pin
  input wire logic ref_supply_in, // Reference supply present
  input wire logic [3:0] filter_cal_result_in, // Trim found by filter cal
  output radio_ctrl_pkg::radio_mode_t mode_out, // Operating mode
  output logic ref_osc_run_out, // Reference oscillator running
  output logic first_regulator_out, // First regulator enable
  output logic second_regulator_out, // Second regulator enable
  output logic tx_osc_regulator_out, // Transmit oscillator regulator
  output logic filter_cal_start_out, // Filter cal start bit
  output logic [3:0] filter_cutoff_trim_out, // Filter trim field
  output logic offset_autocal_trigger_out, // Autocal bit
  output logic [1:0] ref_output_mode_out, // Reference output mode
  output logic upper_range_pick_out, // Upper range choice
  output logic lower_range_pick_out, // Lower range choice
  output logic filter_cal_busy_out, // Filter cal running
  output logic offset_cal_busy_out, // Offset cal running
  output logic [6:0] synth_word_out, // Synthesizer setup word
  output logic [8:0] power_word_out, // Power control word
  output logic [5:0] gain_applied_out, // Gain in effect
  output logic [16:0] divider_applied_out, // Divider in effect
  output logic [3:0] test_one_out, // Test word one
  output logic [3:0] test_two_out // Test word two
);
  import radio_ctrl_pkg::*;

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  logic [7:0] pins_sync;
  pin_sync #(.WIDTH(8)) u_sync (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .pin_in({filter_cal_result_in, ref_supply_in, serial_latch_enable_in,
             serial_data_in, serial_clock_in}),
    .sync_out(pins_sync)
  );
  wire sclk_s = pins_sync[0];
  wire serial_data_in_s = pins_sync[1];
  wire sen_s = pins_sync[2];
  wire ref_s = pins_sync[3];
  wire [3:0] trim_s = pins_sync[7:4];

  // ----------------------------------------
  // Serial shift and edge detection
  // ----------------------------------------
  logic sclk_d_ff;
  logic sen_d_ff;
  logic [SHIFT_W-1:0] shift_ff;
  wire sclk_rise = sclk_s & ~sclk_d_ff;
  wire sen_rise = sen_s & ~sen_d_ff;

  // MSB first, one bit per serial clock rise
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_d_ff <= 1'b0;
      sen_d_ff <= 1'b0;
      shift_ff <= '0;
    end else begin
      sclk_d_ff <= sclk_s;
      sen_d_ff <= sen_s;
      if (sclk_rise) begin
        shift_ff <= {shift_ff[SHIFT_W-2:0], serial_data_in_s};
      end
    end
  end

  // ----------------------------------------
  // Word decode
  // ----------------------------------------
  wire [4:0] addr = shift_ff[ADDR_LSB +: ADDR_W];
  wire [1:0] opc = shift_ff[OP_LSB +: 2];
  wire [16:0] dat = shift_ff[SHIFT_W-1:DATA_LSB];
  wire op_ok = (opc != 2'h3);
  wire wr_en = sen_rise & op_ok;
  wire wr_init = wr_en & (addr == ADDR_INIT);
  wire wr_synth = wr_en & (addr == ADDR_SYNTH);
  wire wr_power = wr_en & (addr == ADDR_POWER);
  wire wr_gain = wr_en & (addr == ADDR_GAIN);
  wire wr_div = wr_en & (addr == ADDR_DIV);
  wire wr_test1 = wr_en & (addr == ADDR_TEST1);
  wire wr_test2 = wr_en & (addr == ADDR_TEST2);

  // Apply opcode to an old value with supplied data or mask
  function automatic logic [16:0] apply_op(input logic [1:0] op, input logic [16:0] old_v,
                                           input logic [16:0] d);
    case (op)
      OP_CLEAR: apply_op = old_v & ~d;
      OP_SET: apply_op = old_v | d;
      default: apply_op = d;
    endcase
  endfunction : apply_op

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [10:0] init_and_setup_word_ff;
  logic [6:0] synth_init_word_ff;
  logic [8:0] power_control_word_ff;
  logic [5:0] gain_control_word_ff;
  logic [16:0] divider_word_ff;
  logic [3:0] test_word_one_ff;
  logic [3:0] test_word_two_ff;
  logic rst_pend_ff;
  logic [FCNT_W-1:0] fcnt_ff;
  logic [OCNT_W-1:0] ocnt_ff;

  wire [16:0] init_old = {6'h00, init_and_setup_word_ff};
  wire [16:0] init_app = apply_op(opc, init_old, dat);
  wire [10:0] nxt_init = init_app[10:0];
  wire [16:0] synth_app = apply_op(opc, {10'h000, synth_init_word_ff}, dat);
  wire [16:0] power_app = apply_op(opc, {8'h00, power_control_word_ff}, dat);
  wire [16:0] gain_app = apply_op(opc, {11'h000, gain_control_word_ff}, dat);
  wire [16:0] div_app = apply_op(opc, divider_word_ff, dat);
  wire [16:0] t1_app = apply_op(opc, {13'h0000, test_word_one_ff}, dat);
  wire [16:0] t2_app = apply_op(opc, {13'h0000, test_word_two_ff}, dat);
  wire soft_reset = wr_init & ~nxt_init[F_RESET];

  // Calibration start and completion
  wire fcal_start = wr_init & ~soft_reset & nxt_init[F_FCAL] &
                    ~init_and_setup_word_ff[F_FCAL];
  wire ocal_start = wr_init & ~soft_reset & nxt_init[F_AUTOCAL] &
                    ~init_and_setup_word_ff[F_AUTOCAL];
  wire fcal_busy = (fcnt_ff != '0);
  wire ocal_busy = (ocnt_ff != '0);
  wire fcal_done = (fcnt_ff == FCNT_W'(1));

  // Init word: serial write, then hardware completion of filter cal
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      init_and_setup_word_ff <= INIT_RST;
      rst_pend_ff <= 1'b0;
    end else if (soft_reset) begin
      init_and_setup_word_ff <= INIT_RST & ~11'h001;
      rst_pend_ff <= 1'b1;
    end else begin
      if (wr_init) begin
        init_and_setup_word_ff <= nxt_init;
      end else if (fcal_done) begin
        init_and_setup_word_ff[F_FCAL] <= 1'b0;
        init_and_setup_word_ff[F_TRIM_LSB +: 4] <= trim_s;
      end
      if (rst_pend_ff && sclk_rise) begin
        init_and_setup_word_ff[F_RESET] <= 1'b1;
        rst_pend_ff <= 1'b0;
      end
    end
  end

  // Remaining words; unallocated addresses touch nothing
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      synth_init_word_ff <= SYNTH_RST;
      power_control_word_ff <= POWER_RST;
      gain_control_word_ff <= GAIN_RST;
      divider_word_ff <= DIV_RST;
      test_word_one_ff <= TEST1_RST;
      test_word_two_ff <= TEST2_RST;
    end else if (soft_reset) begin
      synth_init_word_ff <= SYNTH_RST;
      power_control_word_ff <= POWER_RST;
      gain_control_word_ff <= GAIN_RST;
      divider_word_ff <= DIV_RST;
      test_word_one_ff <= TEST1_RST;
      test_word_two_ff <= TEST2_RST;
    end else begin
      if (wr_synth) synth_init_word_ff <= synth_app[6:0];
      if (wr_power) power_control_word_ff <= power_app[8:0];
      if (wr_gain) gain_control_word_ff <= gain_app[5:0];
      if (wr_div) divider_word_ff <= div_app;
      if (wr_test1) test_word_one_ff <= t1_app[3:0];
      if (wr_test2) test_word_two_ff <= t2_app[3:0];
    end
  end

  // ----------------------------------------
  // Calibration timers
  // ----------------------------------------
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      fcnt_ff <= '0;
      ocnt_ff <= '0;
    end else if (soft_reset) begin
      fcnt_ff <= '0;
      ocnt_ff <= '0;
    end else begin
      if (fcal_start) begin
        fcnt_ff <= FCNT_W'(FCAL_CYCLES);
      end else if (fcal_busy) begin
        fcnt_ff <= fcnt_ff - FCNT_W'(1);
      end
      if (ocal_start) begin
        ocnt_ff <= OCNT_W'(OCAL_CYCLES);
      end else if (ocal_busy) begin
        ocnt_ff <= ocnt_ff - OCNT_W'(1);
      end
    end
  end

  // ----------------------------------------
  // Mode tracking
  // ----------------------------------------
  radio_mode_t mode_ff;
  radio_mode_t nxt_mode;
  wire p_first = power_control_word_ff[P_FIRST_REG];
  wire p_second = power_control_word_ff[P_SECOND_REG];
  wire p_rx = power_control_word_ff[P_RX_ON];
  wire p_tx = power_control_word_ff[P_TX_ON];
  wire p_syn = power_control_word_ff[P_SYN_PU];
  wire alert_ok = p_first & p_second & p_syn;

  // Mode follows reference supply and power word
  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      MODE_PDOWN: if (ref_s) nxt_mode = MODE_WAIT;
      MODE_WAIT: begin
        if (!ref_s) nxt_mode = MODE_PDOWN;
        else if (alert_ok) nxt_mode = MODE_ALERT;
      end
      MODE_ALERT, MODE_RX, MODE_TX: begin
        if (!ref_s) nxt_mode = MODE_PDOWN;
        else if (!alert_ok) nxt_mode = MODE_WAIT;
        else if (p_tx) nxt_mode = MODE_TX;
        else if (p_rx) nxt_mode = MODE_RX;
        else nxt_mode = MODE_ALERT;
      end
      default: nxt_mode = MODE_PDOWN;
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      mode_ff <= MODE_PDOWN;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign mode_out = mode_ff;
  assign ref_osc_run_out = ref_s;
  assign first_regulator_out = p_first;
  assign second_regulator_out = p_second;
  assign tx_osc_regulator_out = p_tx;
  assign filter_cal_start_out = init_and_setup_word_ff[F_FCAL];
  assign filter_cutoff_trim_out = init_and_setup_word_ff[F_TRIM_LSB +: 4];
  assign offset_autocal_trigger_out = init_and_setup_word_ff[F_AUTOCAL];
  assign ref_output_mode_out = init_and_setup_word_ff[F_REFOP_LSB +: 2];
  assign upper_range_pick_out = init_and_setup_word_ff[F_UPPER];
  assign lower_range_pick_out = init_and_setup_word_ff[F_LOWER];
  assign filter_cal_busy_out = fcal_busy;
  assign offset_cal_busy_out = ocal_busy;
  assign synth_word_out = synth_init_word_ff;
  assign power_word_out = power_control_word_ff;
  // Stored words are untouched by cal; held at reset values while offset cal runs
  assign gain_applied_out = ocal_busy ? GAIN_RST : gain_control_word_ff;
  assign divider_applied_out = ocal_busy ? DIV_RST : divider_word_ff;
  assign test_one_out = test_word_one_ff;
  assign test_two_out = test_word_two_ff;
endmodule : radio_ctrl_cal_sequencer

// [radio_ctrl_pkg.sv]
// Notes on behaviour
// - Reference supply present moves power down to wait; oscillator runs at 26 MHz.
// - Transmit section enabled automatically enables the transmit oscillator regulator.
// - Filter cal ends within 1.28 ms, stores trim, hardware clears start bit.
// - Offset cal for both bands completes within 4.3 ms of start.
// - Divider and gain restore after cal; results kept while logic supply stays.
// - Offset cal starts only on autocal rising; high means autocal values used.
// - Five-bit address; only words 0,1,4,5,6,29,31 exist with fixed lengths.
// - Writing zero to reset bit restores defaults; bit returns to one on next serial clock rise.
// - Four-bit trim picks cutoff, zero highest; completed filter cal overwrites it.
// - Reference output mode: normal, counter test, off, high current.
// - Autocal takes upper range from D16 and lower range from D17.
// - Power-on or reset-bit write loads documented defaults.
// - Data shifts MSB first on serial clock rise; word latched on enable rise.
// - Last five bits are address, preceded by two-bit opcode, then data.
// - Opcode: 00 write, 01 masked clear, 10 masked set, 11 reserved.
package radio_ctrl_pkg;
  // ----------------------------------------
  // Serial word layout
  // ----------------------------------------
  localparam int SHIFT_W = 24;
  localparam int ADDR_LSB = 0;
  localparam int ADDR_W = 5;
  localparam int OP_LSB = 5;
  localparam int DATA_LSB = 7;
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_CLEAR = 2'h1;
  localparam logic [1:0] OP_SET = 2'h2;
  // ----------------------------------------
  // Word addresses and data widths
  // ----------------------------------------
  localparam logic [4:0] ADDR_INIT = 5'h00;
  localparam logic [4:0] ADDR_SYNTH = 5'h01;
  localparam logic [4:0] ADDR_POWER = 5'h04;
  localparam logic [4:0] ADDR_GAIN = 5'h05;
  localparam logic [4:0] ADDR_DIV = 5'h06;
  localparam logic [4:0] ADDR_TEST1 = 5'h1D;
  localparam logic [4:0] ADDR_TEST2 = 5'h1F;
  localparam int INIT_W = 11;
  localparam int SYNTH_W = 7;
  localparam int POWER_W = 9;
  localparam int GAIN_W = 6;
  localparam int DIV_W = 17;
  localparam int TEST_W = 4;
  // ----------------------------------------
  // Field positions in the init word (bit 0 is D[7])
  // ----------------------------------------
  localparam int F_RESET = 0;
  localparam int F_FCAL = 1;
  localparam int F_TRIM_LSB = 2;
  localparam int F_AUTOCAL = 6;
  localparam int F_REFOP_LSB = 7;
  localparam int F_UPPER = 9;
  localparam int F_LOWER = 10;
  // Power word fields (bit 0 is D[7])
  localparam int P_FIRST_REG = 0;
  localparam int P_SECOND_REG = 1;
  localparam int P_RX_ON = 2;
  localparam int P_TX_ON = 3;
  localparam int P_SYN_PU = 7;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [10:0] INIT_RST = 11'h001;
  localparam logic [6:0] SYNTH_RST = 7'h00;
  localparam logic [8:0] POWER_RST = 9'h000;
  localparam logic [5:0] GAIN_RST = 6'h00;
  localparam logic [16:0] DIV_RST = 17'h00014;
  localparam logic [3:0] TEST1_RST = 4'h0;
  localparam logic [3:0] TEST2_RST = 4'h4;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int REF_OSC_MHZ = 26;
  localparam int FCAL_TIME_NS = 1280000;
  localparam int OCAL_TIME_NS = 4300000;
  localparam int FCAL_CYC = (FCAL_TIME_NS * CLK_MHZ) / 1000;
  localparam int OCAL_CYC = (OCAL_TIME_NS * CLK_MHZ) / 1000;
  localparam int FCNT_W = 16;
  localparam int OCNT_W = 18;
  // ----------------------------------------
  // Operating modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    MODE_PDOWN,
    MODE_WAIT,
    MODE_ALERT,
    MODE_RX,
    MODE_TX
  } radio_mode_t;
endpackage : radio_ctrl_pkg

// [pin_sync.sv]
`timescale 1ns/10ps
// ----------------------------------------
// Two-flop synchroniser for pin inputs
// ----------------------------------------
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock_in, // System clock
  input wire logic rst_in, // Async reset, active high
  input wire logic [WIDTH-1:0] pin_in, // Asynchronous pin level
  output logic [WIDTH-1:0] sync_out // Synchronised level
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // First stage feeds only the second
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule : pin_sync

// [bb_master.sv]
`timescale 1ns/10ps
// ------------------------------
// Baseband side of the serial bus
// ------------------------------
module bb_master (
  input wire logic clock_in, // System clock
  output logic serial_clock_out, // Serial clock
  output logic serial_data_out, // Serial data
  output logic latch_enable_out // Latch enable
);
  // Clock idles low, nothing latched
  initial begin
    serial_clock_out = 1'b0;
    serial_data_out = 1'b0;
    latch_enable_out = 1'b0;
  end
  // Shift n bits MSB first at 200 ns per bit, then latch
  task automatic send(input logic [23:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_out <= w[i];
      repeat (2) @(posedge clock_in);
      serial_clock_out <= 1'b1;
      repeat (4) @(posedge clock_in);
      serial_clock_out <= 1'b0;
      repeat (2) @(posedge clock_in);
    end
    repeat (2) @(posedge clock_in);
    serial_data_out <= ~serial_data_out; // Data no longer held
    latch_enable_out <= 1'b1;
    repeat (4) @(posedge clock_in);
    latch_enable_out <= 1'b0;
    repeat (6) @(posedge clock_in);
  endtask : send
endmodule : bb_master

// [cal_seq_asserts.sv]
`timescale 1ns/10ps
// ------------------------------
// Port checker
// ------------------------------
module cal_seq_checker
  import radio_ctrl_pkg::*;
#(
  parameter int FCAL_CYCLES = 20,
  parameter int OCAL_CYCLES = 40
) (
  input wire logic clock_in, // Clock
  input wire logic rst_in, // Reset
  input radio_ctrl_pkg::radio_mode_t mode_out, // Mode
  input wire logic ref_osc_run_out, // Ref running
  input wire logic first_regulator_out, // Reg one
  input wire logic second_regulator_out, // Reg two
  input wire logic tx_osc_regulator_out, // Tx reg
  input wire logic offset_autocal_trigger_out, // Autocal bit
  input wire logic filter_cal_start_out, // Start bit
  input wire logic filter_cal_busy_out, // Filter busy
  input wire logic offset_cal_busy_out, // Offset busy
  input wire logic [8:0] power_word_out, // Power word
  input wire logic [5:0] gain_applied_out, // Gain
  input wire logic [16:0] divider_applied_out // Divider
);
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  // Power bits that allow an active mode
  wire syn_ok = ref_osc_run_out & first_regulator_out & second_regulator_out
    & power_word_out[P_SYN_PU];
  wire act = syn_ok & (mode_out != MODE_PDOWN);
  // Wait always steps through alert before a burst mode
  wire run = act & (mode_out != MODE_WAIT);
  wire rx_b = power_word_out[P_RX_ON];
  wire tx_b = power_word_out[P_TX_ON];
  // Busy length counters
  logic [17:0] fcnt_ff;
  logic [17:0] ocnt_ff;
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      fcnt_ff <= 18'h0;
      ocnt_ff <= 18'h0;
    end else begin
      fcnt_ff <= filter_cal_busy_out ? fcnt_ff + 18'h1 : 18'h0;
      ocnt_ff <= offset_cal_busy_out ? ocnt_ff + 18'h1 : 18'h0;
    end
  end
  property p_pdown; !ref_osc_run_out |=> mode_out == MODE_PDOWN; endproperty
  a_pdown: assert property (p_pdown) else $error("not power down");
  property p_wait; ref_osc_run_out && !syn_ok |=> mode_out == MODE_WAIT; endproperty
  a_wait: assert property (p_wait) else $error("not wait");
  property p_alert;
    act && (mode_out == MODE_WAIT || (!rx_b && !tx_b)) |=> mode_out == MODE_ALERT;
  endproperty
  a_alert: assert property (p_alert) else $error("not alert");
  property p_rx; run && rx_b && !tx_b |=> mode_out == MODE_RX; endproperty
  a_rx: assert property (p_rx) else $error("not receive");
  property p_tx; run && tx_b |=> mode_out == MODE_TX; endproperty
  a_tx: assert property (p_tx) else $error("not transmit");
  property p_txreg; mode_out == MODE_TX |-> $past(tx_osc_regulator_out); endproperty
  a_txreg: assert property (p_txreg) else $error("tx regulator off");
  property p_fgo; $rose(filter_cal_start_out) |-> ##[0:1] filter_cal_busy_out; endproperty
  a_fgo: assert property (p_fgo) else $error("filter cal not started");
  property p_fmax; filter_cal_busy_out |-> fcnt_ff < FCAL_CYCLES; endproperty
  a_fmax: assert property (p_fmax) else $error("filter cal too long");
  property p_omax; offset_cal_busy_out |-> ocnt_ff < OCAL_CYCLES; endproperty
  a_omax: assert property (p_omax) else $error("offset cal too long");
  property p_hold;
    offset_cal_busy_out |-> gain_applied_out == GAIN_RST && divider_applied_out == DIV_RST;
  endproperty
  a_hold: assert property (p_hold) else $error("settings not parked");
  property p_orise;
    $rose(offset_autocal_trigger_out) |-> ##[0:1] offset_cal_busy_out;
  endproperty
  a_orise: assert property (p_orise) else $error("offset cal not started");
  property p_ostart; $rose(offset_cal_busy_out) |-> offset_autocal_trigger_out; endproperty
  a_ostart: assert property (p_ostart) else $error("offset cal without bit");
  c_tx: cover property (mode_out == MODE_TX);
  c_fdone: cover property ($fell(filter_cal_busy_out));
  c_odone: cover property ($fell(offset_cal_busy_out));
endmodule : cal_seq_checker
bind radio_ctrl_cal_sequencer cal_seq_checker #(
  .FCAL_CYCLES(FCAL_CYCLES),
  .OCAL_CYCLES(OCAL_CYCLES)
) cal_seq_checker_i (.*);

// [tb.sv]
`timescale 1ns/10ps
module tb;
  import radio_ctrl_pkg::*;
  localparam int FC = 20;
  localparam int OC = 40;
  typedef struct {
    logic [4:0] a;
    logic [1:0] op;
    logic [16:0] d;
    int n;
    logic [4:0] ca;
    logic [16:0] e;
  } row_t;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic ref_supply_in = 1'b0;
  logic [3:0] filter_cal_result_in = 4'h0;
  logic serial_clock_in;
  logic serial_data_in;
  logic serial_latch_enable_in;
  radio_mode_t mode_out;
  logic ref_osc_run_out;
  logic first_regulator_out;
  logic second_regulator_out;
  logic tx_osc_regulator_out;
  logic filter_cal_start_out;
  logic [3:0] filter_cutoff_trim_out;
  logic offset_autocal_trigger_out;
  logic [1:0] ref_output_mode_out;
  logic upper_range_pick_out;
  logic lower_range_pick_out;
  logic filter_cal_busy_out;
  logic offset_cal_busy_out;
  logic [6:0] synth_word_out;
  logic [8:0] power_word_out;
  logic [5:0] gain_applied_out;
  logic [16:0] divider_applied_out;
  logic [3:0] test_one_out;
  logic [3:0] test_two_out;
  int miscompares = 0;
  int cmp_count = 0;
  int fb_n = 0;
  int ob_n = 0;
  // Writes: address, opcode, data, length, word seen, value seen
  row_t rows [14] = '{
    '{ADDR_SYNTH, OP_WRITE, 17'h00055, 14, ADDR_SYNTH, 17'h00055},
    '{ADDR_POWER, OP_WRITE, 17'h000A3, 16, ADDR_POWER, 17'h000A3},
    '{ADDR_POWER, OP_CLEAR, 17'h00003, 16, ADDR_POWER, 17'h000A0},
    '{ADDR_POWER, OP_SET, 17'h00101, 16, ADDR_POWER, 17'h001A1},
    '{ADDR_GAIN, OP_WRITE, 17'h0002A, 13, ADDR_GAIN, 17'h0002A},
    '{ADDR_DIV, OP_WRITE, 17'h1ABCD, 24, ADDR_DIV, 17'h1ABCD},
    '{ADDR_TEST1, OP_WRITE, 17'h00009, 11, ADDR_TEST1, 17'h00009},
    '{ADDR_TEST2, OP_SET, 17'h00002, 11, ADDR_TEST2, 17'h00006},
    '{ADDR_INIT, OP_WRITE, 17'h00795, 18, ADDR_INIT, 17'h003CA},
    '{ADDR_INIT, OP_WRITE, 17'h00081, 18, ADDR_INIT, 17'h00040},
    '{ADDR_INIT, OP_WRITE, 17'h00101, 18, ADDR_INIT, 17'h00080},
    '{ADDR_SYNTH, 2'h3, 17'h0007F, 14, ADDR_SYNTH, 17'h00055},
    '{5'h02, OP_WRITE, 17'h1FFFF, 24, ADDR_SYNTH, 17'h00055},
    '{5'h1E, OP_WRITE, 17'h1FFFF, 24, ADDR_TEST2, 17'h00006}};
  logic [4:0] da [7] = '{ADDR_INIT, ADDR_SYNTH, ADDR_POWER, ADDR_GAIN, ADDR_DIV,
    ADDR_TEST1, ADDR_TEST2};
  logic [16:0] dv [7] = '{17'h0, 17'h0, 17'h0, 17'h0, 17'h00014, 17'h0, 17'h00004};
  logic [8:0] pw [6] = '{9'h083, 9'h087, 9'h083, 9'h08B, 9'h083, 9'h000};
  radio_mode_t pm [6] = '{MODE_ALERT, MODE_RX, MODE_ALERT, MODE_TX, MODE_ALERT, MODE_WAIT};
  radio_ctrl_cal_sequencer #(.FCAL_CYCLES(FC), .OCAL_CYCLES(OC))
    radio_ctrl_cal_sequencer_i (.*);
  bb_master bb_master_i (
    .clock_in(clock_in),
    .serial_clock_out(serial_clock_in),
    .serial_data_out(serial_data_in),
    .latch_enable_out(serial_latch_enable_in)
  );
  always #12.5 clock_in = ~clock_in;
  // Cycles each calibration stays busy
  always @(posedge clock_in) begin
    if (filter_cal_busy_out === 1'b1) fb_n <= fb_n + 1;
    if (offset_cal_busy_out === 1'b1) ob_n <= ob_n + 1;
  end
  // Register word as seen at the ports
  function automatic logic [16:0] obs(input logic [4:0] a);
    case (a)
      ADDR_INIT: obs = {7'h0, lower_range_pick_out, upper_range_pick_out,
        ref_output_mode_out, offset_autocal_trigger_out, filter_cutoff_trim_out,
        filter_cal_start_out};
      ADDR_SYNTH: obs = {10'h0, synth_word_out};
      ADDR_POWER: obs = {8'h0, power_word_out};
      ADDR_GAIN: obs = {11'h0, gain_applied_out};
      ADDR_DIV: obs = divider_applied_out;
      ADDR_TEST1: obs = {13'h0, test_one_out};
      default: obs = {13'h0, test_two_out};
    endcase
  endfunction : obs
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [1:0] op, input logic [16:0] d,
    input int n);
    bb_master_i.send({d, op, a}, n);
  endtask : wr
  task automatic chk_dflt();
    foreach (da[i]) chk(obs(da[i]), dv[i]);
  endtask : chk_dflt
  task automatic cal_wait();
    for (int k = 0; k < 200 && offset_cal_busy_out !== 1'b0; k++)
      @(posedge clock_in);
    repeat (2) @(posedge clock_in);
    chk(offset_cal_busy_out, 1'b0);
  endtask : cal_wait
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (40000) @(posedge clock_in);
    miscompares++;
    $display("BAD %0t watchdog expired", $time);
    test_done();
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    chk(mode_out, MODE_PDOWN);
    chk_dflt();
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].op, rows[i].d, rows[i].n);
      chk(obs(rows[i].ca), rows[i].e);
    end
    ref_supply_in <= 1'b1;
    repeat (6) @(posedge clock_in);
    chk(ref_osc_run_out, 1'b1);
    chk(mode_out, MODE_WAIT);
    foreach (pw[i]) begin
      wr(ADDR_POWER, OP_WRITE, {8'h0, pw[i]}, 16);
      chk(mode_out, pm[i]);
      chk(tx_osc_regulator_out, pm[i] == MODE_TX);
      chk({first_regulator_out, second_regulator_out}, {pw[i][0], pw[i][1]});
    end
    ref_supply_in <= 1'b0;
    repeat (6) @(posedge clock_in);
    chk(mode_out, MODE_PDOWN);
    ref_supply_in <= 1'b1;
    filter_cal_result_in <= 4'hA;
    wr(ADDR_POWER, OP_WRITE, 17'h00087, 16);
    repeat (2000) @(posedge clock_in);
    wr(ADDR_INIT, OP_WRITE, 17'h00243, 18);
    chk(filter_cal_busy_out, 1'b1);
    chk(gain_applied_out, 6'h0);
    chk(divider_applied_out, 17'h00014);
    cal_wait();
    chk(17'(fb_n), 17'(FC));
    chk(17'(ob_n), 17'(OC));
    chk(filter_cal_start_out, 1'b0);
    chk(filter_cutoff_trim_out, 4'hA);
    chk(offset_autocal_trigger_out, 1'b1);
    chk(upper_range_pick_out, 1'b1);
    chk(gain_applied_out, 6'h2A);
    chk(divider_applied_out, 17'h1ABCD);
    wr(ADDR_INIT, OP_SET, 17'h00040, 18);
    cal_wait();
    chk(17'(ob_n), 17'(OC));
    wr(ADDR_INIT, OP_CLEAR, 17'h00040, 18);
    chk(offset_autocal_trigger_out, 1'b0);
    wr(ADDR_INIT, OP_SET, 17'h00040, 18);
    chk(offset_cal_busy_out, 1'b1);
    cal_wait();
    chk(17'(ob_n), 17'(2 * OC));
    ref_supply_in <= 1'b0;
    repeat (6) @(posedge clock_in);
    chk(filter_cutoff_trim_out, 4'hA);
    wr(ADDR_INIT, OP_WRITE, 17'h00000, 18);
    chk_dflt();
    wr(ADDR_SYNTH, OP_WRITE, 17'h00033, 14);
    chk(synth_word_out, 7'h33);
    wr(ADDR_INIT, OP_SET, 17'h00040, 18);
    chk(offset_autocal_trigger_out, 1'b1);
    test_done();
  end
endmodule : tb
